/* core/ldc_pkg.sv */
package ldc_pkg;

  // Register offsets on the serial register port
  localparam logic [7:0] LDC_OFS_DCFG  = 8'h08;
  localparam logic [7:0] LDC_OFS_TRGH  = 8'h0B;
  localparam logic [7:0] LDC_OFS_SCTL  = 8'h0C;
  localparam logic [7:0] LDC_OFS_CONV  = 8'h41;
  localparam logic [7:0] LDC_OFS_PEAKC = 8'h42;
  localparam logic [7:0] LDC_OFS_PEAKV = 8'h43;
  localparam logic [7:0] LDC_OFS_ZCTL  = 8'h44;
  localparam logic [7:0] LDC_OFS_TSD   = 8'h4C;
  localparam logic [7:0] LDC_OFS_TREC  = 8'h4D;
  localparam logic [7:0] LDC_OFS_TEMP  = 8'h4E;

  // Reset values
  localparam logic [7:0] LDC_RST_REG   = 8'h00;
  localparam logic [7:0] LDC_RST_TSD   = 8'h40;
  localparam logic [7:0] LDC_RST_TREC  = 8'h50;

  // Field positions
  localparam int LDC_DCFG_NOLA  = 3;
  localparam int LDC_SCTL_CONT  = 6;
  localparam int LDC_SCTL_EN    = 7;
  localparam int LDC_PEAK_MAX   = 0;
  localparam int LDC_PEAK_CLR   = 7;
  localparam int LDC_ZCTL_CH_LO = 5;

  // Timing
  localparam int LDC_CLK_NS       = 50;
  localparam int LDC_WAKE_NS      = 150;
  localparam int LDC_WAKE_CYC     = LDC_WAKE_NS / LDC_CLK_NS;
  localparam int LDC_LA_DEPTH     = 6;
  localparam logic [7:0] LDC_SIXTEENTH_MIN = 8'h01;

  typedef enum logic [1:0] {
    LDC_MODE_NIB   = 2'b00,
    LDC_MODE_SPLIT = 2'b01,
    LDC_MODE_SEQ   = 2'b10,
    LDC_MODE_REG   = 2'b11
  } ldc_mode_t;

  typedef struct packed {
    logic [9:0] ch3;
    logic [9:0] ch2;
    logic [9:0] ch1;
  } ldc_pixel_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ldc_regreq_t;

endpackage : ldc_pkg

/* core/ldc_output_control.sv */
`timescale 1ns/100ps
`default_nettype none
module ldc_output_control
  import ldc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        sleep_request,
  input  wire logic        zero_pulse_request,
  input  wire logic        pixel_clk,
  input  wire logic [7:0]  die_temp_code,
  input  wire ldc_pixel_t  pixel_in,
  input  wire logic [7:0]  adc_code,
  input  wire ldc_regreq_t reg_req,
  output logic [7:0]       reg_rdata,
  output ldc_pixel_t       laser_driver_out,
  output logic             dac_zero,
  output logic [2:0]       bias_en,
  output logic [15:0]      segment_en,
  output logic             sample_strobe,
  output logic [2:0]       sampler_gain,
  output logic [7:0]       converter_cfg,
  output logic             thermal_shutdown
);

  localparam logic [2:0] WAKE_CYC = 3'(LDC_WAKE_CYC);

  typedef struct packed {
    logic [1:0]             sync_sleep;
    logic [1:0]             sync_zero;
    logic [1:0]             sync_pclk;
    logic [7:0]             sync_temp1;
    logic [7:0]             sync_temp2;
    logic                   pclk_d;
    logic [7:0]             data_interface_config;
    logic [7:0]             sampler_target_high;
    logic [7:0]             sampler_control;
    logic [7:0]             converter_control;
    logic [7:0]             peak_detect_control;
    logic [7:0]             zero_pulse_control;
    logic [7:0]             overtemp_threshold;
    logic [7:0]             overtemp_recovery;
    logic [7:0]             peak_value;
    logic [7:0]             rdata;
    logic                   shut;
    logic                   asleep;
    logic [2:0]             wake_cnt;
    logic [7:0]             per_cnt;
    logic [7:0]             period;
    logic [7:0]             ph_cnt;
    logic                   armed;
    logic [2:0]             zero_ch;
    logic [LDC_LA_DEPTH-1:0][29:0] pipe;
    ldc_pixel_t             out;
    logic [2:0]             bias;
    logic [15:0]            seg;
    logic                   strobe;
  } ldc_state_t;

  ldc_state_t st;
  ldc_state_t next_st;

  logic        pclk_rise;
  logic        pclk_fall;
  logic        force_zero;
  logic [7:0]  sixteenth;
  logic [7:0]  pulse_start;
  logic [9:0]  target_code;
  logic [9:0]  sel_code;
  ldc_pixel_t  src;
  ldc_mode_t   mode;
  logic        la_on;

  always_comb begin
    mode        = ldc_mode_t'(st.data_interface_config[1:0]);
    la_on       = ~st.data_interface_config[LDC_DCFG_NOLA];
    pclk_rise   = st.sync_pclk[1] & ~st.pclk_d;
    pclk_fall   = ~st.sync_pclk[1] & st.pclk_d;
    target_code = {st.sampler_target_high, st.sampler_control[1:0]};
    sixteenth   = {4'h0, st.period[7:4]};
    if (sixteenth < LDC_SIXTEENTH_MIN) begin
      sixteenth = LDC_SIXTEENTH_MIN;
    end
    unique case (st.zero_pulse_control[1:0])
      2'b00:   pulse_start = sixteenth;
      2'b01:   pulse_start = 8'(sixteenth * 8'h03);
      default: pulse_start = 8'(sixteenth * 8'h05);
    endcase
    // Sleep, waking and overtemperature all hold the DACs at zero
    force_zero = st.asleep | (st.wake_cnt != 3'h0) | st.shut;
    src = la_on ? ldc_pixel_t'(st.pipe[LDC_LA_DEPTH-1]) : pixel_in;
    unique case (st.sampler_control[3:2])
      2'b00:   sel_code = st.out.ch1;
      2'b01:   sel_code = st.out.ch2;
      2'b10:   sel_code = st.out.ch3;
      default: sel_code = ~target_code;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.sync_sleep = {st.sync_sleep[0], sleep_request};
    next_st.sync_zero  = {st.sync_zero[0], zero_pulse_request};
    next_st.sync_pclk  = {st.sync_pclk[0], pixel_clk};
    next_st.sync_temp1 = die_temp_code;
    next_st.sync_temp2 = st.sync_temp1;
    next_st.pclk_d     = st.sync_pclk[1];
    next_st.strobe     = 1'b0;
    next_st.peak_detect_control[LDC_PEAK_CLR] = 1'b0;

    // Register writes; sleep never touches these
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        LDC_OFS_DCFG:  next_st.data_interface_config = reg_req.wdata;
        LDC_OFS_TRGH:  next_st.sampler_target_high   = reg_req.wdata;
        LDC_OFS_SCTL:  next_st.sampler_control       = reg_req.wdata;
        LDC_OFS_CONV:  next_st.converter_control     = reg_req.wdata;
        LDC_OFS_PEAKC: next_st.peak_detect_control   = reg_req.wdata;
        LDC_OFS_ZCTL:  next_st.zero_pulse_control    = reg_req.wdata;
        LDC_OFS_TSD:   next_st.overtemp_threshold    = reg_req.wdata;
        LDC_OFS_TREC:  next_st.overtemp_recovery     = reg_req.wdata;
        default:       next_st.rdata                 = st.rdata;
      endcase
    end

    unique case (reg_req.addr)
      LDC_OFS_DCFG:  next_st.rdata = st.data_interface_config;
      LDC_OFS_TRGH:  next_st.rdata = st.sampler_target_high;
      LDC_OFS_SCTL:  next_st.rdata = st.sampler_control;
      LDC_OFS_CONV:  next_st.rdata = st.converter_control;
      LDC_OFS_PEAKC: next_st.rdata = st.peak_detect_control;
      LDC_OFS_PEAKV: next_st.rdata = st.peak_value;
      LDC_OFS_ZCTL:  next_st.rdata = st.zero_pulse_control;
      LDC_OFS_TSD:   next_st.rdata = st.overtemp_threshold;
      LDC_OFS_TREC:  next_st.rdata = st.overtemp_recovery;
      LDC_OFS_TEMP:  next_st.rdata = st.sync_temp2;
      default:       next_st.rdata = 8'h00;
    endcase

    // Sleep entry and timed recovery
    if (st.sync_sleep[1]) begin
      next_st.asleep   = 1'b1;
      next_st.wake_cnt = 3'h0;
    end else if (st.asleep) begin
      next_st.asleep   = 1'b0;
      next_st.wake_cnt = WAKE_CYC;
    end else if (st.wake_cnt != 3'h0) begin
      next_st.wake_cnt = st.wake_cnt - 3'h1;
    end

    // Overtemperature with hysteresis
    if (st.overtemp_threshold > st.sync_temp2) begin
      next_st.shut = 1'b1;
    end else if (st.shut && st.sync_temp2 > st.overtemp_recovery) begin
      next_st.shut = 1'b0;
    end

    // Pixel clock period measured in system clocks
    if (pclk_rise) begin
      next_st.period  = st.per_cnt;
      next_st.per_cnt = 8'h01;
    end else if (st.per_cnt != 8'hFF) begin
      next_st.per_cnt = st.per_cnt + 8'h01;
    end

    // Zero-pulse arming per pixel
    if (st.ph_cnt != 8'hFF) begin
      next_st.ph_cnt = st.ph_cnt + 8'h01;
    end
    if ((mode == LDC_MODE_SEQ) ? pclk_rise : pclk_fall) begin
      next_st.armed  = st.sync_zero[1];
      next_st.ph_cnt = 8'h00;
    end
    if (mode == LDC_MODE_REG) begin
      next_st.zero_ch = {3{st.sync_zero[1]}};
    end else if (st.armed && st.ph_cnt >= pulse_start &&
                 st.ph_cnt < 8'(pulse_start + sixteenth)) begin
      next_st.zero_ch = st.zero_pulse_control[LDC_ZCTL_CH_LO +: 3];
    end else begin
      next_st.zero_ch = 3'h0;
    end

    // Look-ahead delay line and data path
    next_st.pipe = {st.pipe[LDC_LA_DEPTH-2:0], pixel_in};
    if (force_zero) begin
      next_st.out  = '0;
      next_st.bias = 3'h0;
      next_st.seg  = 16'h0000;
    end else begin
      next_st.out.ch1 = src.ch1 & {10{~st.zero_ch[0]}};
      next_st.out.ch2 = src.ch2 & {10{~st.zero_ch[1]}};
      next_st.out.ch3 = src.ch3 & {10{~st.zero_ch[2]}};
      if (la_on) begin
        next_st.bias = {|src.ch3, 1'b1, |src.ch1};
        for (int i = 0; i < 16; i++) begin
          next_st.seg[i] = (src.ch2 != 10'h000) &&
                           (src.ch2[9:6] >= 4'(i));
        end
      end else begin
        next_st.bias = 3'h7;
        next_st.seg  = 16'hFFFF;
      end
    end

    // Sampler trigger on target code
    if (st.sampler_control[LDC_SCTL_EN] && sel_code == target_code) begin
      next_st.strobe = 1'b1;
      if (!st.sampler_control[LDC_SCTL_CONT] &&
          !(reg_req.wr && reg_req.addr == LDC_OFS_SCTL &&
            reg_req.wdata[LDC_SCTL_EN])) begin
        next_st.sampler_control[LDC_SCTL_EN] = 1'b0;
      end
    end

    // Peak tracking of converted samples
    if (st.peak_detect_control[LDC_PEAK_CLR]) begin
      next_st.peak_value = st.peak_detect_control[LDC_PEAK_MAX] ? 8'h00
                                                                : 8'hFF;
    end else if (st.strobe) begin
      if (st.peak_detect_control[LDC_PEAK_MAX] ? adc_code > st.peak_value
                                               : adc_code < st.peak_value) begin
        next_st.peak_value = adc_code;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.overtemp_threshold <= LDC_RST_TSD;
      st.overtemp_recovery  <= LDC_RST_TREC;
      st.peak_value         <= LDC_RST_REG;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata        = st.rdata;
  assign laser_driver_out = st.out;
  assign dac_zero         = force_zero;
  assign bias_en          = st.bias;
  assign segment_en       = st.seg;
  assign sample_strobe    = st.strobe;
  assign sampler_gain     = 3'h1 + {1'b0, st.sampler_control[5:4]};
  assign converter_cfg    = st.converter_control;
  assign thermal_shutdown = st.shut;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_sleep_zero_out: assert property (
    st.asleep |=> laser_driver_out == '0 && bias_en == 3'h0)
    else $error("output not zero during sleep");
  chk_sleep_keeps_cfg: assert property (
    !reg_req.wr && $rose(st.asleep) |=> $stable(st.data_interface_config))
    else $error("config changed on sleep entry");
  chk_wake_time: assert property (
    $fell(st.asleep) |-> dac_zero [*3] ##1 !dac_zero || st.asleep || st.shut)
    else $error("wake time wrong");
  chk_la_latency: assert property (
    la_on && !force_zero && st.zero_ch == 3'h0 |=>
      laser_driver_out == $past(st.pipe[LDC_LA_DEPTH-1]))
    else $error("look-ahead latency wrong");
  chk_bias_cut: assert property (
    la_on && !force_zero && src.ch1 == 10'h000 |=> !bias_en[0])
    else $error("bias not cut on zero data");
  chk_oneshot_clear: assert property (
    sample_strobe && !st.sampler_control[LDC_SCTL_CONT] && !reg_req.wr
      |-> !st.sampler_control[LDC_SCTL_EN])
    else $error("single shot enable not cleared");
  chk_shutdown_set: assert property (
    st.overtemp_threshold > st.sync_temp2 |=> thermal_shutdown && dac_zero)
    else $error("shutdown missed");
  chk_recovery: assert property (
    st.shut && st.overtemp_threshold <= st.sync_temp2 &&
      st.sync_temp2 > st.overtemp_recovery |=> !thermal_shutdown)
    else $error("recovery missed");
  chk_async_gate: assert property (
    mode == LDC_MODE_REG && st.sync_zero[1] ##1 !force_zero
      |=> laser_driver_out == '0)
    else $error("async gate failed");

  cov_sleep_wake:   cover property ($fell(st.asleep) ##[1:5] !dac_zero);
  cov_sync_pulse:   cover property (st.zero_ch != 3'h0 && mode == LDC_MODE_NIB);
  cov_oneshot:      cover property (sample_strobe ##1
                                    !st.sampler_control[LDC_SCTL_EN]);
  cov_thermal_trip: cover property ($rose(thermal_shutdown) ##[1:50]
                                    $fell(thermal_shutdown));

endmodule : ldc_output_control
`default_nettype wire

/* bench/ldc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ldc_host_model (
  input  wire logic clk_run,
  input  wire logic sleep_cmd,
  input  wire logic zp_cmd,
  output logic      pixel_clk,
  output logic      sleep_request,
  output logic      zero_pulse_request
);
  logic zp_q;

  // Pixel clock runs only within frames and stands low between them
  initial begin
    pixel_clk = 1'b0;
    zp_q      = 1'b0;
    #13;
    forever begin
      #200;
      pixel_clk = clk_run ? ~pixel_clk : 1'b0;
    end
  end

  // Within frames, zero-pulse pin changes on pixel clock rise, held over the fall; between frames it follows zp_cmd directly
  always @(posedge pixel_clk) begin
    zp_q <= zp_cmd;
  end

  assign sleep_request      = sleep_cmd;
  assign zero_pulse_request = clk_run ? zp_q : zp_cmd;
endmodule : ldc_host_model
`default_nettype wire

/* bench/ldc_output_control_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module ldc_output_control_tb_top;
  import ldc_pkg::*;
  logic        clk, rst_n, pixel_clk, sleep_request, zero_pulse_request;
  logic        clk_run, sleep_cmd, zp_cmd, dac_zero, sample_strobe;
  logic        thermal_shutdown;
  logic [7:0]  die_temp_code, adc_code, reg_rdata, converter_cfg;
  logic [2:0]  bias_en, sampler_gain;
  logic [15:0] segment_en;
  ldc_pixel_t  pixel_in, laser_driver_out;
  ldc_regreq_t reg_req;
  int          n_mismatch, n_checks, hits;

  ldc_host_model i_ldc_host_model (.clk_run(clk_run), .sleep_cmd(sleep_cmd),
    .zp_cmd(zp_cmd), .pixel_clk(pixel_clk), .sleep_request(sleep_request),
    .zero_pulse_request(zero_pulse_request));

  ldc_output_control i_ldc_output_control (.clk(clk), .rst_n(rst_n),
    .sleep_request(sleep_request), .zero_pulse_request(zero_pulse_request),
    .pixel_clk(pixel_clk), .die_temp_code(die_temp_code),
    .pixel_in(pixel_in), .adc_code(adc_code), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .laser_driver_out(laser_driver_out),
    .dac_zero(dac_zero), .bias_en(bias_en), .segment_en(segment_en),
    .sample_strobe(sample_strobe), .sampler_gain(sampler_gain),
    .converter_cfg(converter_cfg), .thermal_shutdown(thermal_shutdown));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic end_sim();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_req = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge clk);
    reg_req.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_req = '{wr: 1'b0, addr: a, wdata: 8'h00};
    repeat (2) @(negedge clk);
    chk(reg_rdata, exp);
  endtask : rd

  task automatic wait_strobe();
    for (int i = 0; i < 60; i++) begin
      @(negedge clk);
      if (sample_strobe === 1'b1) return;
    end
    n_mismatch++;
    end_sim();
  endtask : wait_strobe

  task automatic t_reset_regs();
    rd(LDC_OFS_TSD, LDC_RST_TSD);
    rd(LDC_OFS_TREC, LDC_RST_TREC);
    rd(LDC_OFS_DCFG, 8'h00);
    rd(LDC_OFS_SCTL, 8'h00);
    rd(8'h3A, 8'h00);
    chk(sampler_gain, 3'h1);
    wr(LDC_OFS_CONV, 8'h5A);
    wr(LDC_OFS_TEMP, 8'h11);
    rd(LDC_OFS_CONV, 8'h5A);
    chk(converter_cfg, 8'h5A);
    rd(LDC_OFS_TEMP, 8'h80);
  endtask : t_reset_regs

  task automatic t_sleep();
    sleep_cmd = 1'b1;
    repeat (4) @(negedge clk);
    chk(dac_zero, 1'b1);
    chk(laser_driver_out, '0);
    rd(LDC_OFS_CONV, 8'h5A);
    sleep_cmd = 1'b0;
    repeat (5) @(negedge clk);
    chk(dac_zero, 1'b1);
    repeat (3) @(negedge clk);
    chk(dac_zero, 1'b0);
    rd(LDC_OFS_TSD, LDC_RST_TSD);
  endtask : t_sleep

  task automatic t_thermal();
    die_temp_code = 8'h30;
    repeat (5) @(negedge clk);
    chk(thermal_shutdown, 1'b1);
    chk(dac_zero, 1'b1);
    rd(LDC_OFS_TEMP, 8'h30);
    die_temp_code = 8'h48;
    repeat (5) @(negedge clk);
    chk(thermal_shutdown, 1'b1);
    die_temp_code = 8'h60;
    repeat (5) @(negedge clk);
    chk(thermal_shutdown, 1'b0);
  endtask : t_thermal

  task automatic t_sampler();
    wr(LDC_OFS_DCFG, 8'h08);
    pixel_in = '{ch3: 10'h101, ch2: 10'h101, ch1: 10'h101};
    wr(LDC_OFS_TRGH, 8'h40);
    wr(LDC_OFS_SCTL, 8'hB1);
    wait_strobe();
    chk(sampler_gain, 3'h4);
    rd(LDC_OFS_SCTL, 8'h31);
    wr(LDC_OFS_SCTL, 8'hF1);
    wait_strobe();
    wait_strobe();
    rd(LDC_OFS_SCTL, 8'hF1);
    adc_code = 8'h37;
    wr(LDC_OFS_PEAKC, 8'h81);
    wait_strobe();
    wait_strobe();
    rd(LDC_OFS_PEAKV, 8'h37);
    rd(LDC_OFS_PEAKC, 8'h01);
    wr(LDC_OFS_SCTL, 8'h71);
    hits = 0;
    repeat (3) @(negedge clk);
    repeat (10) begin
      @(negedge clk);
      if (sample_strobe !== 1'b0) hits++;
    end
    chk(hits, 0);
    pixel_in = '{ch3: 10'h155, ch2: 10'h155, ch1: 10'h3FF};
    repeat (4) @(negedge clk);
    chk(sample_strobe, 1'b0);
  endtask : t_sampler

  task automatic t_lookahead();
    wr(LDC_OFS_DCFG, 8'h00);
    pixel_in = '{ch3: 10'h000, ch2: 10'h040, ch1: 10'h3FF};
    repeat (10) @(negedge clk);
    chk(bias_en, 3'h3);
    chk(segment_en, 16'h0003);
    chk(laser_driver_out.ch1, 10'h3FF);
    pixel_in = '{ch3: 10'h000, ch2: 10'h040, ch1: 10'h000};
    repeat (6) @(negedge clk);
    chk(laser_driver_out.ch1, 10'h3FF);
    @(negedge clk);
    chk(laser_driver_out.ch1, 10'h000);
    chk(bias_en, 3'h2);
  endtask : t_lookahead

  task automatic t_zero_pulse();
    wr(LDC_OFS_ZCTL, 8'h20);
    clk_run = 1'b1;
    zp_cmd  = 1'b1;
    hits    = 0;
    repeat (60) begin
      @(negedge clk);
      if (laser_driver_out.ch1 === 10'h000) hits++;
      chk(laser_driver_out.ch2, 10'h155);
    end
    chk(hits > 3, 1'b1);
    zp_cmd = 1'b0;
    repeat (30) @(negedge clk);
    clk_run = 1'b0;
    chk(laser_driver_out.ch1, 10'h3FF);
    // Field mode entered with look-ahead off
    wr(LDC_OFS_DCFG, 8'h0B);
    zp_cmd = 1'b1;
    repeat (6) @(negedge clk);
    chk(laser_driver_out.ch1, 10'h000);
    zp_cmd = 1'b0;
    repeat (6) @(negedge clk);
    chk(laser_driver_out.ch1, 10'h3FF);
  endtask : t_zero_pulse

  initial begin
    rst_n = 1'b0;
    clk_run = 1'b0;
    sleep_cmd = 1'b0;
    zp_cmd = 1'b0;
    die_temp_code = 8'h80;
    adc_code = 8'h00;
    pixel_in = '0;
    reg_req = '0;
    n_mismatch = 0;
    n_checks = 0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_reset_regs();
    t_sleep();
    t_thermal();
    t_lookahead();
    t_sampler();
    t_zero_pulse();
    end_sim();
  end
endmodule : ldc_output_control_tb_top
`default_nettype wire
